// ===== logic/tec_consts.svh
/*
 * Register indices, field positions, masks, reset values and event action codes
 * of the timer event and interrupt control block.
 * Assumes a 32-bit AXI4-Lite slave where the byte address is four times the index.
 */
`ifndef TEC_CONSTS_SVH
`define TEC_CONSTS_SVH

`define TEC_ADDR_W 12
`define TEC_IDX_DBGCTL 10'h008
`define TEC_IDX_EVCTL 10'h00A
`define TEC_IDX_IENCLR 10'h00C
`define TEC_IDX_IENSET 10'h00D
`define TEC_IDX_STATUS 10'h020
`define TEC_IDX_STCLR 10'h021

`define TEC_EVCTL_MASK 16'h3137
`define TEC_EVCTL_LOCKED 16'h0007
`define TEC_IRQ_MASK 8'h3B
`define TEC_EVCTL_RST 16'h0000
`define TEC_IRQ_RST 8'h00
`define TEC_DBG_RST 1'b0

`define TEC_BIT_RUN_HALT 0
`define TEC_BIT_INV 4
`define TEC_BIT_INEN 5
`define TEC_BIT_WRAPEO 8
`define TEC_BIT_CHEO0 12
`define TEC_IRQ_WRAP 0
`define TEC_IRQ_ERR 1
`define TEC_IRQ_SYNC 3
`define TEC_IRQ_CH0 4

`define TEC_ACT_OFF 3'h0
`define TEC_ACT_RETRIG 3'h1
`define TEC_ACT_COUNT 3'h2
`define TEC_ACT_START 3'h3
`define TEC_ACT_PERIOD0 3'h5
`define TEC_ACT_PERIOD1 3'h6

`endif

// ===== logic/tec_pkg.sv
/*
 * Types shared by the register slave and the event control core.
 * Assumes the constants header for widths of indices.
 */
package tec_pkg;

    // One register write handed from the bus slave to the core
    typedef struct packed {
        logic valid;
        logic [9:0] idx;
        logic [31:0] data;
        logic [3:0] strb;
    } tec_wreq_type;

    typedef struct packed {
        logic aw_have;
        logic w_have;
        logic [9:0] widx;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tec_axil_state_type;

    typedef struct packed {
        logic dbg_run;
        logic [15:0] evctl;
        logic [7:0] irq_en;
        logic [7:0] status;
        logic sync_prev;
        logic halt;
        logic [1:0] chan_ev;
        logic wrap_ev;
        logic retrig;
        logic count;
        logic start;
        logic [1:0] cap_en;
        logic cap_period_chan;
        logic cap_src;
    } tec_core_state_type;

endpackage

// ===== logic/tec_axil_slave.sv
/*
 * AXI4-Lite slave front end: takes write address and data in either order,
 * hands one write request to the core, answers reads from the core's mux.
 * Assumes the core decodes indices combinationally and flags unmapped ones.
 */
`timescale 1ns/1ns
`include "tec_consts.svh"

module tec_axil_slave
    import tec_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Write channels
    input wire logic [`TEC_ADDR_W-1:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    // Read channels
    input wire logic [`TEC_ADDR_W-1:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    // Core side
    output tec_wreq_type wreq_out,
    input wire logic wr_err_in,
    output logic [9:0] rd_idx_out,
    input wire logic [31:0] rd_data_in,
    input wire logic rd_err_in
);

    tec_axil_state_type s_r;
    tec_axil_state_type s_nxt;

    assign awready_out = !s_r.aw_have && !s_r.bvalid;
    assign wready_out = !s_r.w_have && !s_r.bvalid;
    assign bvalid_out = s_r.bvalid;
    assign bresp_out = s_r.bresp;
    assign arready_out = !s_r.rvalid;
    assign rvalid_out = s_r.rvalid;
    assign rdata_out = s_r.rdata;
    assign rresp_out = s_r.rresp;
    assign rd_idx_out = araddr_in[`TEC_ADDR_W-1:2];
    assign wreq_out = '{valid: s_r.aw_have && s_r.w_have, idx: s_r.widx,
                        data: s_r.wdata, strb: s_r.wstrb};

    always_comb begin
        s_nxt = s_r;
        if (awvalid_in && awready_out) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.widx = awaddr_in[`TEC_ADDR_W-1:2];
        end
        if (wvalid_in && wready_out) begin
            s_nxt.w_have = 1'b1;
            s_nxt.wdata = wdata_in;
            s_nxt.wstrb = wstrb_in;
        end
        // Both halves held: the write lands this cycle, response follows
        if (s_r.aw_have && s_r.w_have) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = wr_err_in ? 2'h2 : 2'h0;
        end
        if (s_r.bvalid && bready_in) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_r.rvalid && rready_in) begin
            s_nxt.rvalid = 1'b0;
        end
        if (arvalid_in && arready_out) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd_data_in;
            s_nxt.rresp = rd_err_in ? 2'h2 : 2'h0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

// ===== logic/tec_core.sv
/*
 * Timer event and interrupt control: debug-run bit, event control register,
 * shared interrupt enables, sticky interrupt status, event in/out routing.
 * Assumes the counter core, the event network and the sync logic all run on
 * clk_sys_in and deliver one-cycle pulses; the core reports its enable level.
 */
`timescale 1ns/1ns
`include "tec_consts.svh"

//////////////////////////////////////////////////////////////////////////////
// Functional notes
// R1 - Debug-run bit survives software reset; only the hardware reset clears it.
// R2 - Debug-run 0 halts the timer in debug halt; 1 keeps it running.
// R3 - Software should not change debug-run while the timer is enabled.
// R4 - Channel event-out enables pass match/capture pulses as output events, else none.
// R5 - Wrap event-out enable passes overflow/underflow pulses as output events.
// R6 - Event-input enable gates incoming events; clear means ignored.
// R7 - Inversion bit inverts the incoming source for period/width capture only.
// R8 - Action 0 none, 1 retrigger, 2 count step, 3 start.
// R9 - Action 5 period to channel 0; action 6 period to channel 1.
// R10 - Event action field changes only while the timer is disabled.
// R11 - Output enables, input enable and inversion stay writable while enabled.
// R12 - Reserved bits read zero; software writes zero there.
// R13 - Writing one to enable-clear clears that enable; zero leaves it.
// R14 - Writing one to enable-set sets that enable; zero leaves it.
// R15 - Set and clear registers share one enable state and read it back.
// R16 - Enables: wrap bit 0, error 1, sync done 3, channels 5:4.
// R17 - Reserved actions 4 and 7 act as no action.
// R18 - A channel flag requests an interrupt only while its enable is set.
// R19 - Sync-done flag sets when sync busy falls, unless enable or reset caused it.
module tec_core
    import tec_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // AXI4-Lite write channels
    input wire logic [`TEC_ADDR_W-1:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    // AXI4-Lite read channels
    input wire logic [`TEC_ADDR_W-1:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    // Counter core status
    input wire logic timer_enabled_in,
    input wire logic sw_reset_in,
    input wire logic debug_halted_in,
    input wire logic sync_in_progress_in,
    input wire logic sync_fall_by_enable_in,
    // Counter core events
    input wire logic [1:0] chan_match_capture_in,
    input wire logic wraparound_in,
    input wire logic capture_error_in,
    // Event network
    input wire logic event_in,
    output logic [1:0] chan_event_out,
    output logic wrap_event_out,
    // Counter core controls
    output logic timer_halt_out,
    output logic retrigger_out,
    output logic count_step_out,
    output logic start_out,
    output logic [1:0] capture_en_out,
    output logic capture_period_chan_out,
    output logic capture_src_out,
    // Interrupt
    output logic irq_out
);

    tec_core_state_type s_r;
    tec_core_state_type s_nxt;
    tec_wreq_type wreq;
    logic [9:0] rd_idx;
    logic [31:0] rd_data;
    logic rd_err;
    logic wr_err;

    tec_axil_slave u_slave (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .awaddr_in(awaddr_in),
        .awvalid_in(awvalid_in),
        .awready_out(awready_out),
        .wdata_in(wdata_in),
        .wstrb_in(wstrb_in),
        .wvalid_in(wvalid_in),
        .wready_out(wready_out),
        .bresp_out(bresp_out),
        .bvalid_out(bvalid_out),
        .bready_in(bready_in),
        .araddr_in(araddr_in),
        .arvalid_in(arvalid_in),
        .arready_out(arready_out),
        .rdata_out(rdata_out),
        .rresp_out(rresp_out),
        .rvalid_out(rvalid_out),
        .rready_in(rready_in),
        .wreq_out(wreq),
        .wr_err_in(wr_err),
        .rd_idx_out(rd_idx),
        .rd_data_in(rd_data),
        .rd_err_in(rd_err)
    );

    //////////////////////////////////////////////////////////////////////////
    // Register read mux and address decode

    function automatic logic mapped(input logic [9:0] idx);
        mapped = (idx == `TEC_IDX_DBGCTL) || (idx == `TEC_IDX_EVCTL) ||
                 (idx == `TEC_IDX_IENCLR) || (idx == `TEC_IDX_IENSET) ||
                 (idx == `TEC_IDX_STATUS) || (idx == `TEC_IDX_STCLR);
    endfunction

    assign wr_err = !mapped(wreq.idx);
    assign rd_err = !mapped(rd_idx);

    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (rd_idx)
            `TEC_IDX_DBGCTL: rd_data[`TEC_BIT_RUN_HALT] = s_r.dbg_run;
            `TEC_IDX_EVCTL: rd_data[15:0] = s_r.evctl & `TEC_EVCTL_MASK; // [R12]
            `TEC_IDX_IENCLR,
            `TEC_IDX_IENSET: rd_data[7:0] = s_r.irq_en & `TEC_IRQ_MASK; // [R15] [R12]
            `TEC_IDX_STATUS: rd_data[7:0] = s_r.status & `TEC_IRQ_MASK;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [15:0] lane_mask;
        logic [15:0] ev_new;
        logic [7:0] st_set;
        logic [7:0] st_clr;
        logic [2:0] act;
        logic ev_ok;
        logic cap_mode;
        lane_mask = {{8{wreq.strb[1]}}, {8{wreq.strb[0]}}};
        ev_new = 16'h0000;
        st_set = 8'h00;
        st_clr = 8'h00;
        act = s_r.evctl[2:0];
        ev_ok = event_in && s_r.evctl[`TEC_BIT_INEN]; // [R6]
        cap_mode = (act == `TEC_ACT_PERIOD0) || (act == `TEC_ACT_PERIOD1);
        s_nxt = s_r;

        // Register writes; narrow registers take the low byte lane only
        if (wreq.valid) begin
            unique case (wreq.idx)
                `TEC_IDX_DBGCTL: begin
                    if (wreq.strb[0]) begin
                        s_nxt.dbg_run = wreq.data[`TEC_BIT_RUN_HALT];
                    end
                end
                `TEC_IDX_EVCTL: begin
                    ev_new = (s_r.evctl & ~lane_mask) | (wreq.data[15:0] & lane_mask);
                    if (timer_enabled_in) begin
                        // Action is locked while running; other fields stay open
                        ev_new = (ev_new & ~`TEC_EVCTL_LOCKED) |
                                 (s_r.evctl & `TEC_EVCTL_LOCKED); // [R10] [R11]
                    end
                    s_nxt.evctl = ev_new & `TEC_EVCTL_MASK; // [R12]
                end
                `TEC_IDX_IENCLR: begin
                    if (wreq.strb[0]) begin
                        s_nxt.irq_en = s_r.irq_en & ~(wreq.data[7:0] & `TEC_IRQ_MASK); // [R13]
                    end
                end
                `TEC_IDX_IENSET: begin
                    if (wreq.strb[0]) begin
                        s_nxt.irq_en = s_r.irq_en | (wreq.data[7:0] & `TEC_IRQ_MASK); // [R14]
                    end
                end
                `TEC_IDX_STCLR: begin
                    if (wreq.strb[0]) begin
                        st_clr = wreq.data[7:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Sticky status; a set in the clearing cycle wins
        st_set[`TEC_IRQ_WRAP] = wraparound_in; // [R16]
        st_set[`TEC_IRQ_ERR] = capture_error_in;
        st_set[`TEC_IRQ_SYNC] = s_r.sync_prev && !sync_in_progress_in &&
                                !sync_fall_by_enable_in && !sw_reset_in; // [R19]
        st_set[`TEC_IRQ_CH0 +: 2] = chan_match_capture_in;
        s_nxt.status = ((s_r.status & ~st_clr) | st_set) & `TEC_IRQ_MASK;
        s_nxt.sync_prev = sync_in_progress_in;

        // Halt request follows debug state unless run-in-debug is set
        s_nxt.halt = debug_halted_in && !s_r.dbg_run; // [R2]

        // Outgoing events
        s_nxt.chan_ev = chan_match_capture_in &
                        s_r.evctl[`TEC_BIT_CHEO0 +: 2]; // [R4]
        s_nxt.wrap_ev = wraparound_in && s_r.evctl[`TEC_BIT_WRAPEO]; // [R5]

        // Incoming event actions; codes 4 and 7 fall through to nothing
        s_nxt.retrig = ev_ok && (act == `TEC_ACT_RETRIG); // [R8] [R17]
        s_nxt.count = ev_ok && (act == `TEC_ACT_COUNT); // [R8]
        s_nxt.start = ev_ok && (act == `TEC_ACT_START); // [R8]
        s_nxt.cap_en = {2{cap_mode && s_r.evctl[`TEC_BIT_INEN]}}; // [R9]
        s_nxt.cap_period_chan = (act == `TEC_ACT_PERIOD1); // [R9]
        s_nxt.cap_src = cap_mode && s_r.evctl[`TEC_BIT_INEN] &&
                        (event_in ^ s_r.evctl[`TEC_BIT_INV]); // [R7]

        // Software reset returns event control, enables and status; the debug-run bit is kept
        if (sw_reset_in) begin
            s_nxt.evctl = `TEC_EVCTL_RST;
            s_nxt.irq_en = `TEC_IRQ_RST;
            s_nxt.status = `TEC_IRQ_RST;
            s_nxt.dbg_run = s_r.dbg_run; // [R1]
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs

    assign chan_event_out = s_r.chan_ev;
    assign wrap_event_out = s_r.wrap_ev;
    assign timer_halt_out = s_r.halt;
    assign retrigger_out = s_r.retrig;
    assign count_step_out = s_r.count;
    assign start_out = s_r.start;
    assign capture_en_out = s_r.cap_en;
    assign capture_period_chan_out = s_r.cap_period_chan;
    assign capture_src_out = s_r.cap_src;
    // Only enabled flags reach the line
    assign irq_out = |(s_r.status & s_r.irq_en); // [R18]

    //////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    logic wr_ev;
    logic wr_clr;
    logic wr_set;
    logic wr_dbg;
    assign wr_ev = wreq.valid && (wreq.idx == `TEC_IDX_EVCTL);
    assign wr_clr = wreq.valid && (wreq.idx == `TEC_IDX_IENCLR) && wreq.strb[0];
    assign wr_set = wreq.valid && (wreq.idx == `TEC_IDX_IENSET) && wreq.strb[0];
    assign wr_dbg = wreq.valid && (wreq.idx == `TEC_IDX_DBGCTL);

    property p_dbg_keep;
        sw_reset_in && !wr_dbg |=> $stable(s_r.dbg_run);
    endproperty
    a_dbg_keep: assert property (p_dbg_keep) else $error("debug run lost"); // [R1]

    property p_halt;
        debug_halted_in |=> (timer_halt_out == !$past(s_r.dbg_run));
    endproperty
    a_halt: assert property (p_halt) else $error("halt wrong"); // [R2]

    property p_chan_ev;
        chan_match_capture_in[1] |=> (chan_event_out[1] == $past(s_r.evctl[13]));
    endproperty
    a_chan_ev: assert property (p_chan_ev) else $error("chan event wrong"); // [R4]

    property p_wrap_ev;
        !wraparound_in |=> !wrap_event_out;
    endproperty
    a_wrap_ev: assert property (p_wrap_ev) else $error("spurious wrap event"); // [R5]

    property p_in_gate;
        !s_r.evctl[`TEC_BIT_INEN] |=> !retrigger_out && !count_step_out && !start_out;
    endproperty
    a_in_gate: assert property (p_in_gate) else $error("event not gated"); // [R6]

    property p_count;
        event_in && s_r.evctl[`TEC_BIT_INEN] && (s_r.evctl[2:0] == `TEC_ACT_COUNT)
            |=> count_step_out && !retrigger_out && !start_out;
    endproperty
    a_count: assert property (p_count) else $error("count step missing"); // [R8]

    property p_resv_act;
        (s_r.evctl[2:0] == 3'h4 || s_r.evctl[2:0] == 3'h7)
            |=> !retrigger_out && !count_step_out && !start_out;
    endproperty
    a_resv_act: assert property (p_resv_act) else $error("reserved action acted"); // [R17]

    property p_act_lock;
        wr_ev && timer_enabled_in && !sw_reset_in |=> $stable(s_r.evctl[2:0]);
    endproperty
    a_act_lock: assert property (p_act_lock) else $error("action changed"); // [R10]

    property p_ien_clr;
        wr_clr && wreq.data[`TEC_IRQ_CH0] |=> !s_r.irq_en[`TEC_IRQ_CH0];
    endproperty
    a_ien_clr: assert property (p_ien_clr) else $error("enable not cleared"); // [R13]

    property p_ien_set;
        wr_set && wreq.data[`TEC_IRQ_SYNC] && !sw_reset_in |=> s_r.irq_en[`TEC_IRQ_SYNC];
    endproperty
    a_ien_set: assert property (p_ien_set) else $error("enable not set"); // [R14]

    property p_irq;
        s_r.status[`TEC_IRQ_CH0] && !s_r.irq_en[`TEC_IRQ_CH0] && irq_out
            |-> |(s_r.status & s_r.irq_en & 8'h2F);
    endproperty
    a_irq: assert property (p_irq) else $error("irq from masked flag"); // [R18]

    property p_sync;
        s_r.sync_prev && !sync_in_progress_in && !sync_fall_by_enable_in && !sw_reset_in
            |=> s_r.status[`TEC_IRQ_SYNC];
    endproperty
    a_sync: assert property (p_sync) else $error("sync done missed"); // [R19]

    c_retrig: cover property (retrigger_out);
    c_capture: cover property (capture_en_out == 2'h3 && capture_src_out);
    c_irq: cover property (!irq_out ##1 irq_out);
    c_lock: cover property (wr_ev && timer_enabled_in);

endmodule

// ===== testbench/tec_peer_model.sv
/*
 * Far side model: counter core and event network pulses, sync busy window.
 * Assumes the bench drives fire_in right after a rising edge, one cycle each.
 */
`timescale 1ns/1ns

module tec_peer_model (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Bench requests: sync start, error, wrap, chan 1, chan 0, event
    input wire logic [5:0] fire_in,
    input wire logic level_in,
    input wire logic by_enable_in,
    // Towards the block
    output logic event_out,
    output logic [1:0] chan_match_capture_out,
    output logic wraparound_out,
    output logic capture_error_out,
    output logic sync_in_progress_out,
    output logic sync_fall_by_enable_out
);

logic [5:0] fire_r;
logic [1:0] busy_r;
logic busy_prev_r;

always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        fire_r <= 6'h00;
        busy_r <= 2'h0;
        busy_prev_r <= 1'b0;
    end else begin
        fire_r <= fire_in;
        busy_prev_r <= (busy_r != 2'h0);
        if (fire_in[5]) begin
            busy_r <= 2'h3;
        end else if (busy_r != 2'h0) begin
            busy_r <= busy_r - 2'h1;
        end
    end
end

// Pulses last one cycle, like the real counter core
assign event_out = fire_r[0] | level_in;
assign chan_match_capture_out = fire_r[2:1];
assign wraparound_out = fire_r[3];
assign capture_error_out = fire_r[4];
assign sync_in_progress_out = (busy_r != 2'h0);
// Fall cause flagged only in the falling cycle
assign sync_fall_by_enable_out = by_enable_in & busy_prev_r & (busy_r == 2'h0);

endmodule

// ===== testbench/timer_event_irq_control_test.sv
/*
 * Self-checking bench for tec_core: register rows, then events, interrupts,
 * debug halt and resets. Assumes tec_peer_model stands for the far side.
 */
`timescale 1ns/1ns
`include "tec_consts.svh"

module timer_event_irq_control_test import tec_pkg::*;;

typedef struct packed {
    logic [9:0] idx;
    logic [31:0] wv;
    logic [31:0] rv;
    logic [1:0] resp;
} tec_row_type;

logic clk_sys_in;
logic rst_n_in = 1'b0;
logic [11:0] awaddr_in = 12'h000;
logic [11:0] araddr_in = 12'h000;
logic awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0;
logic arvalid_in = 1'b0, rready_in = 1'b0;
logic [31:0] wdata_in = 32'h0000_0000;
logic [3:0] wstrb_in = 4'h0;
logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
logic [1:0] bresp_out, rresp_out;
logic [31:0] rdata_out;
logic timer_enabled_in = 1'b0, sw_reset_in = 1'b0, debug_halted_in = 1'b0;
logic lvl = 1'b0, byen = 1'b0;
logic [5:0] fire = 6'h00;
logic event_in, wraparound_in, capture_error_in;
logic sync_in_progress_in, sync_fall_by_enable_in;
logic [1:0] chan_match_capture_in, chan_event_out, capture_en_out;
logic wrap_event_out, timer_halt_out, retrigger_out, count_step_out, start_out;
logic capture_period_chan_out, capture_src_out, irq_out;
int mismatches = 0, checked = 0, cycles = 0;
logic [1:0] r;
logic [31:0] d;
tec_row_type rows [6] = '{
    '{`TEC_IDX_EVCTL, 32'h0000_FFFF, 32'h0000_3137, 2'h0},
    '{`TEC_IDX_IENSET, 32'h0000_00FF, 32'h0000_003B, 2'h0},
    '{`TEC_IDX_IENCLR, 32'h0000_0001, 32'h0000_003A, 2'h0},
    '{`TEC_IDX_DBGCTL, 32'h0000_00FF, 32'h0000_0001, 2'h0},
    '{`TEC_IDX_STCLR, 32'h0000_00FF, 32'h0000_0000, 2'h0},
    '{10'h010, 32'h0000_FFFF, 32'h0000_0000, 2'h2}
};

tec_core u_tec_core (
    .clk_sys_in, .rst_n_in, .awaddr_in, .awvalid_in, .awready_out,
    .wdata_in, .wstrb_in, .wvalid_in, .wready_out, .bresp_out, .bvalid_out,
    .bready_in, .araddr_in, .arvalid_in, .arready_out, .rdata_out,
    .rresp_out, .rvalid_out, .rready_in, .timer_enabled_in, .sw_reset_in,
    .debug_halted_in, .sync_in_progress_in, .sync_fall_by_enable_in,
    .chan_match_capture_in, .wraparound_in, .capture_error_in, .event_in,
    .chan_event_out, .wrap_event_out, .timer_halt_out, .retrigger_out,
    .count_step_out, .start_out, .capture_en_out, .capture_period_chan_out,
    .capture_src_out, .irq_out
);

tec_peer_model u_tec_peer_model (
    .clk_sys_in, .rst_n_in, .fire_in(fire), .level_in(lvl),
    .by_enable_in(byen), .event_out(event_in),
    .chan_match_capture_out(chan_match_capture_in),
    .wraparound_out(wraparound_in), .capture_error_out(capture_error_in),
    .sync_in_progress_out(sync_in_progress_in),
    .sync_fall_by_enable_out(sync_fall_by_enable_in)
);

initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
end

//////////////////////////////////////////////////////////////////////////////

task automatic results;
    $display("Checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
endtask

// Cuts a hung handshake short
always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 6000) begin
        mismatches++;
        results();
    end
end

task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
        mismatches++;
        $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
endtask

task automatic wr(input logic [9:0] idx, input logic [31:0] v, output logic [1:0] resp);
    @(posedge clk_sys_in);
    awaddr_in <= {idx, 2'b00};
    wdata_in <= v;
    wstrb_in <= 4'hF;
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    bready_in <= 1'b1;
    do begin
        @(posedge clk_sys_in);
        if (awready_out) awvalid_in <= 1'b0;
        if (wready_out) wvalid_in <= 1'b0;
    end while (bvalid_out !== 1'b1);
    resp = bresp_out;
    bready_in <= 1'b0;
endtask

task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
    @(posedge clk_sys_in);
    araddr_in <= {idx, 2'b00};
    arvalid_in <= 1'b1;
    rready_in <= 1'b1;
    do begin
        @(posedge clk_sys_in);
        if (arready_out) arvalid_in <= 1'b0;
    end while (rvalid_out !== 1'b1);
    d = rdata_out;
    r = rresp_out;
    rready_in <= 1'b0;
    check(d, exp);
endtask

// Partner pulse, then one edge for the block to answer
task automatic fire_ev(input logic [5:0] v);
    @(posedge clk_sys_in);
    fire <= v;
    @(posedge clk_sys_in);
    fire <= 6'h00;
    @(posedge clk_sys_in);
    #1;
endtask

function automatic logic [31:0] exp_act(input int a);
    exp_act = {26'h0, a == 1, a == 2, a == 3, (a == 5 || a == 6) ? 2'h3 : 2'h0, a == 6};
endfunction

//////////////////////////////////////////////////////////////////////////////

initial begin
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 6; i++) rchk(rows[i].idx, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
        wr(rows[i].idx, rows[i].wv, r);
        check(32'(r), 32'(rows[i].resp));
        rchk(rows[i].idx, rows[i].rv);
        check(32'(r), 32'(rows[i].resp));
    end
    $display("Register rows done");
    for (int a = 0; a < 8; a++) begin
        wr(`TEC_IDX_EVCTL, 32'h0000_0020 | 32'(a), r);
        fire_ev(6'h01);
        check(32'({retrigger_out, count_step_out, start_out, capture_en_out,
                   capture_period_chan_out}), exp_act(a));
    end
    wr(`TEC_IDX_EVCTL, 32'h0000_0001, r);
    fire_ev(6'h01);
    check(32'(retrigger_out), 32'h0);
    wr(`TEC_IDX_EVCTL, 32'h0000_0035, r);
    lvl <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1 check(32'(capture_src_out), 32'h0);
    wr(`TEC_IDX_EVCTL, 32'h0000_0025, r);
    repeat (2) @(posedge clk_sys_in);
    #1 check(32'(capture_src_out), 32'h1);
    lvl <= 1'b0;
    // Action locked while running, output enables still writable
    wr(`TEC_IDX_EVCTL, 32'h0000_0001, r);
    timer_enabled_in <= 1'b1;
    wr(`TEC_IDX_EVCTL, 32'h0000_3132, r);
    rchk(`TEC_IDX_EVCTL, 32'h0000_3131);
    fire_ev(6'h0E);
    check(32'({chan_event_out, wrap_event_out}), 32'h7);
    wr(`TEC_IDX_EVCTL, 32'h0000_2000, r);
    fire_ev(6'h0E);
    check(32'({chan_event_out, wrap_event_out}), 32'h4);
    timer_enabled_in <= 1'b0;
    $display("Event tests done");
    wr(`TEC_IDX_STCLR, 32'h0000_003B, r);
    wr(`TEC_IDX_IENSET, 32'h0000_0001, r);
    fire_ev(6'h08);
    rchk(`TEC_IDX_STATUS, 32'h0000_0001);
    check(32'(irq_out), 32'h1);
    wr(`TEC_IDX_IENCLR, 32'h0000_0001, r);
    check(32'(irq_out), 32'h0);
    wr(`TEC_IDX_STCLR, 32'h0000_0001, r);
    fire_ev(6'h02);
    rchk(`TEC_IDX_STATUS, 32'h0000_0010);
    check(32'(irq_out), 32'h1);
    wr(`TEC_IDX_IENCLR, 32'h0000_0010, r);
    check(32'(irq_out), 32'h0);
    wr(`TEC_IDX_STCLR, 32'h0000_0010, r);
    fire_ev(6'h10);
    fire_ev(6'h20);
    repeat (8) @(posedge clk_sys_in);
    rchk(`TEC_IDX_STATUS, 32'h0000_000A);
    wr(`TEC_IDX_STCLR, 32'h0000_000A, r);
    byen <= 1'b1;
    fire_ev(6'h20);
    repeat (8) @(posedge clk_sys_in);
    rchk(`TEC_IDX_STATUS, 32'h0000_0000);
    byen <= 1'b0;
    $display("Interrupt tests done");
    // Debug-run changed only with the timer disabled
    debug_halted_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1 check(32'(timer_halt_out), 32'h0);
    wr(`TEC_IDX_DBGCTL, 32'h0000_0000, r);
    repeat (2) @(posedge clk_sys_in);
    #1 check(32'(timer_halt_out), 32'h1);
    wr(`TEC_IDX_DBGCTL, 32'h0000_0001, r);
    debug_halted_in <= 1'b0;
    wr(`TEC_IDX_EVCTL, 32'h0000_1120, r);
    sw_reset_in <= 1'b1;
    @(posedge clk_sys_in);
    sw_reset_in <= 1'b0;
    rchk(`TEC_IDX_DBGCTL, 32'h0000_0001);
    rchk(`TEC_IDX_EVCTL, 32'h0000_0000);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rchk(`TEC_IDX_DBGCTL, 32'h0000_0000);
    $display("Debug and reset tests done");
    results();
end

endmodule
